//--- hdl/tog_pkg.sv
// Constants and types shared by the output gating block
package tog_pkg;

	// Delays in converter clock cycles from an input edge to start or mute
	localparam int unsigned TOG_DLY_PLAIN   = 93;
	localparam int unsigned TOG_DLY_SOFT    = 133;
	// Least legal pulse widths on the gate input, in cycles
	localparam int unsigned TOG_PW_QUICK    = 20;
	localparam int unsigned TOG_PW_SLOW     = 102;
	// Counter width covering every figure above
	localparam int unsigned TOG_CNT_W       = 8;

	// Gate states, Gray coded along idle -> wait on -> on -> wait off
	typedef enum logic [1:0] {
		TOG_MUTED    = 2'h0,
		TOG_STARTING = 2'h1,
		TOG_ACTIVE   = 2'h3,
		TOG_MUTING   = 2'h2
	} tog_state_t;

endpackage

//--- hdl/tog_delay_count.sv
// Loadable down counter that flags when a programmed delay has elapsed
`timescale 1ns/10ps
module tog_delay_count #(
	parameter int unsigned WIDTH = 8
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             reset,
	// Control
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] load_value,
	// Status
	output logic                  done
);

	logic [WIDTH-1:0] count_q;

	// Load wins over counting so a fresh edge always restarts the delay
	always_ff @(posedge clk) begin
		if (reset) begin
			count_q <= '0;
		end else if (load) begin
			count_q <= load_value;
		end else if (count_q != '0) begin
			count_q <= count_q - 1'b1;
		end
	end

	// Done in the cycle the count reaches one, so a load of N ends N cycles later
	assign done = (count_q == {{(WIDTH-1){1'b0}}, 1'b1}) && !load;

endmodule

//--- hdl/tog_output_gate.sv
// Transmit enable output gating: edge to start and edge to mute timing
`timescale 1ns/10ps
// Operation
// - Quick enable: output starts 93 cycles after rise, 133 with soft transition.
// - Slow enable: start waits for link ready plus digital path latency.
// - Output mutes 93 cycles after fall, 133 with soft transition.
// - Quick enable may ignore too-short pulses, leaving output unchanged.
module tog_output_gate
	import tog_pkg::*;
#(
	parameter int unsigned CNT_W    = TOG_CNT_W,
	parameter int unsigned DLY_PLAIN = TOG_DLY_PLAIN,
	parameter int unsigned DLY_SOFT  = TOG_DLY_SOFT,
	parameter int unsigned PW_QUICK  = TOG_PW_QUICK
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             reset,
	// Configuration selections
	input  wire logic             quick_enable,
	input  wire logic             soft_transition,
	// Host gate input
	input  wire logic             output_gate_input,
	// Slow path: link up and the digital path latency in cycles
	input  wire logic             link_ready,
	input  wire logic [CNT_W-1:0] digital_path_latency,
	// Status
	output logic                  output_on,
	output logic                  pulse_ignored
);

	// Delay line geometry: the filter spends the first PW_QUICK cycles of every delay,
	// the line supplies the rest, and the output flop adds the final cycle
	localparam int unsigned LINE_N    = DLY_SOFT - PW_QUICK + 1;
	localparam int unsigned TAP_PLAIN = DLY_PLAIN - PW_QUICK - 1;
	localparam int unsigned TAP_SOFT  = DLY_SOFT - PW_QUICK - 1;

	tog_state_t        state_q;
	logic              gate_q;
	logic              rise;
	logic              fall;
	logic [CNT_W-1:0]  width_q;
	logic              accept;
	logic              held_q;
	logic [LINE_N-1:0] line_q;
	logic              tap;
	logic              tap_prev;
	logic              tap_fall;
	logic              short_end;
	logic              load;
	logic [CNT_W-1:0]  load_value;
	logic              done;
	logic              slow_wait_q;
	logic              on_q;
	logic              ign_q;

	// Edge detect on the gate input, taken as synchronous to clk
	always_ff @(posedge clk) begin
		if (reset) begin
			gate_q <= 1'b0;
		end else begin
			gate_q <= output_gate_input;
		end
	end
	assign rise = output_gate_input && !gate_q;
	assign fall = !output_gate_input && gate_q;

	// Cycles the input has held its present level, saturating at the quick minimum
	always_ff @(posedge clk) begin
		if (reset) begin
			width_q <= '0;
		end else if (rise || fall) begin
			width_q <= CNT_W'(1);
		end else if (width_q < CNT_W'(PW_QUICK)) begin
			width_q <= width_q + 1'b1;
		end
	end

	// A level is accepted once it has stood for the quick minimum; a shorter pulse
	// never reaches the filtered copy, so in quick mode the output cannot see it at all
	assign accept = !rise && !fall && (width_q == CNT_W'(PW_QUICK - 1));

	// Filtered copy of the gate input; legal slow pulses are far longer than the
	// filter, so slow mode uses the same copy for its mute timing
	always_ff @(posedge clk) begin
		if (reset) begin
			held_q <= 1'b0;
		end else if (accept) begin
			held_q <= output_gate_input;
		end
	end

	// Delay line of the filtered level. Pulses may be as short as the quick minimum
	// while the delay is several times longer, so several edges can be in flight;
	// a single reloadable counter would lose all but the newest of them.
	always_ff @(posedge clk) begin
		if (reset) begin
			line_q <= '0;
		end else begin
			line_q <= {line_q[LINE_N-2:0], held_q};
		end
	end

	// Tap picked by the soft transition selection; the next older bit gives the edge
	assign tap      = soft_transition ? line_q[TAP_SOFT] : line_q[TAP_PLAIN];
	assign tap_prev = soft_transition ? line_q[TAP_SOFT + 1] : line_q[TAP_PLAIN + 1];
	assign tap_fall = tap_prev && !tap;

	// A quick pulse that ends before it was accepted is reported as dropped
	assign short_end = quick_enable && (rise || fall) && (gate_q != held_q)
		&& (width_q < CNT_W'(PW_QUICK));

	// Slow starts count the path latency once the link is up
	assign load       = (state_q == TOG_STARTING) && slow_wait_q && link_ready;
	assign load_value = digital_path_latency;

	// Counter serves slow starts only; quick timing comes from the delay line
	tog_delay_count #(
		.WIDTH(CNT_W)
	) u_delay (
		.clk        (clk),
		.reset      (reset),
		.load       (load),
		.load_value (load_value),
		.done       (done)
	);

	// Slow starts first wait for the link, then count the path latency
	always_ff @(posedge clk) begin
		if (reset) begin
			slow_wait_q <= 1'b0;
		end else if (rise && !quick_enable) begin
			slow_wait_q <= 1'b1;
		end else if (link_ready || fall) begin
			slow_wait_q <= 1'b0;
		end
	end

	// Slow gate state machine; quick mode leaves it idle in the muted state.
	// A slow mute ends on the delayed fall unless a new rise sends it back to starting, since every accepted pulse
	// travels down the line and its falling edge is bound to arrive.
	always_ff @(posedge clk) begin
		if (reset) begin
			state_q <= TOG_MUTED;
		end else begin
			case (state_q)
				TOG_MUTED: begin
					if (rise && !quick_enable) begin
						state_q <= TOG_STARTING;
					end
				end
				TOG_STARTING: begin
					if (fall) begin
						state_q <= TOG_MUTING;
					end else if (done && !slow_wait_q) begin
						state_q <= TOG_ACTIVE;
					end
				end
				TOG_ACTIVE: begin
					if (fall) begin
						state_q <= TOG_MUTING;
					end
				end
				TOG_MUTING: begin
					if (rise) begin
						state_q <= TOG_STARTING;
					end else if (tap_fall) begin
						state_q <= TOG_MUTED;
					end
				end
				default: begin
					state_q <= TOG_MUTED;
				end
			endcase
		end
	end

	// Output flag from a flop. Quick mode follows the delayed filtered level, so
	// muted holds until a start has travelled the full delay. In slow mode a new
	// start wins over an older delayed fall that lands in the same cycle.
	always_ff @(posedge clk) begin
		if (reset) begin
			on_q <= 1'b0;
		end else if (quick_enable) begin
			on_q <= tap;
		end else if (state_q == TOG_STARTING && done && !slow_wait_q && !fall) begin
			on_q <= 1'b1;
		end else if (tap_fall) begin
			on_q <= 1'b0;
		end
	end

	// One-cycle flag when a quick pulse was too short and was dropped
	always_ff @(posedge clk) begin
		if (reset) begin
			ign_q <= 1'b0;
		end else begin
			ign_q <= short_end;
		end
	end

	assign output_on     = on_q;
	assign pulse_ignored = ign_q;

endmodule

//--- bench/tog_host_model.sv
// Host model that drives gate pulses on the falling clock edge
`timescale 1ns/10ps
module tog_host_model (
	// Clock
	input  wire logic clk,
	// Gate toward the block
	output logic      output_gate_input
);
	initial output_gate_input = 1'b0;
	// High for hi cycles, then low for lo; callers pick the widths
	task automatic pulse(input int hi, input int lo);
		@(negedge clk);
		output_gate_input = 1'b1;
		repeat (hi) @(negedge clk);
		output_gate_input = 1'b0;
		repeat (lo) @(negedge clk);
	endtask
endmodule

//--- bench/tog_output_gate_assertions.sv
// Port timing checks for the output gating block
`timescale 1ns/10ps
module tog_output_gate_assertions (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Watched ports
	input wire logic quick_enable,
	input wire logic soft_transition,
	input wire logic output_gate_input,
	input wire logic link_ready,
	input wire logic output_on,
	input wire logic pulse_ignored
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// Quick starts and all mutes land exactly one delay after the input edge
	a_quick_start: assert property ($rose(output_on) && quick_enable |->
		soft_transition ? ($past(output_gate_input, 134) && !$past(output_gate_input, 135))
		: ($past(output_gate_input, 94) && !$past(output_gate_input, 95))) else $error("start delay");
	a_mute_delay: assert property ($fell(output_on) |->
		soft_transition ? (!$past(output_gate_input, 134) && $past(output_gate_input, 135))
		: (!$past(output_gate_input, 94) && $past(output_gate_input, 95))) else $error("mute delay");
	a_slow_start: assert property ($rose(output_on) && !quick_enable |-> $past(link_ready))
		else $error("slow start without link");
	a_stay_muted: assert property (!output_on && !quick_enable && !link_ready |=> !output_on)
		else $error("output left mute");
	a_ignore_pulse: assert property (pulse_ignored |-> quick_enable && $stable(output_on) ##1 !pulse_ignored)
		else $error("bad ignore flag");
	cover property ($rose(output_on) && quick_enable);
	cover property ($rose(output_on) && !quick_enable);
	cover property (pulse_ignored);
endmodule
bind tog_output_gate tog_output_gate_assertions i_chk (.clk, .reset, .quick_enable, .soft_transition,
	.output_gate_input, .link_ready, .output_on, .pulse_ignored);

//--- bench/tog_output_gate_tb.sv
// Self-checking bench for the output gating block
`timescale 1ns/10ps
module tog_output_gate_tb;
	import tog_pkg::*;
	logic clk = 1'b0, reset = 1'b1, quick_enable = 1'b1, soft_transition = 1'b0, link_ready = 1'b0;
	logic [TOG_CNT_W-1:0] digital_path_latency = 8'h01;
	logic output_gate_input, output_on, pulse_ignored;
	int miscompares = 0, comparisons = 0, cycles = 0, ignores = 0, seed = 21, dly = 93;
	bit ref_en = 1'b0;
	bit hist[$];
	always #50 clk = ~clk;
	tog_host_model i_tog_host_model (.clk, .output_gate_input);
	tog_output_gate i_tog_output_gate (.clk, .reset, .quick_enable, .soft_transition, .output_gate_input,
		.link_ready, .digital_path_latency, .output_on, .pulse_ignored);
	task automatic check_on(input logic exp);
		comparisons++;
		if (output_on !== exp) begin
			miscompares++;
			$display("[FAIL] %0t output_on wrong", $time);
		end
	endtask
	task automatic check_val(input int got, input int exp);
		comparisons++;
		if (got != exp) begin
			miscompares++;
			$display("[FAIL] %0t count wrong", $time);
		end
	endtask
	task automatic complete_run();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// Reference history: quick mode repeats the input one delay later; bounded to stay cheap
	always @(posedge clk) begin
		cycles++;
		hist.push_front(output_gate_input);
		if (hist.size() > 140) void'(hist.pop_back());
		if (pulse_ignored === 1'b1) ignores++;
		if (cycles > 5000) begin
			miscompares++;
			complete_run();
		end
	end
	always @(negedge clk) if (ref_en && hist.size() > dly) check_on(hist[dly]);
	initial begin
		repeat (3) @(negedge clk);
		reset = 1'b0;
		ref_en = 1'b1;
		for (int s = 0; s < 2; s++) begin
			soft_transition = s[0];
			dly = s ? 133 : 93;
			i_tog_host_model.pulse(20, 200);
			i_tog_host_model.pulse(25, 25);
			i_tog_host_model.pulse(30, 200);
			i_tog_host_model.pulse(20 + {$random(seed)} % 60, 200);
			$display("quick test soft %0d done", s);
		end
		ref_en = 1'b0;
		i_tog_host_model.pulse(19, 200);
		check_on(1'b0);
		check_val(ignores, 1);
		$display("ignore test done");
		quick_enable = 1'b0;
		digital_path_latency = 8'h01 + 8'({$random(seed)} % 30);
		fork
			i_tog_host_model.pulse(300, 200);
		join_none
		repeat (50) @(negedge clk);
		check_on(1'b0);
		link_ready = 1'b1;
		repeat (digital_path_latency) @(negedge clk);
		check_on(1'b0);
		@(negedge clk);
		check_on(1'b1);
		wait fork;
		check_on(1'b0);
		$display("slow test done");
		complete_run();
	end
endmodule
